// *** core/dram_refresh_defines.svh ***
/*
 * Timing and geometry constants for the dynamic RAM refresh and cycle controller.
 * Assumes a 50 MHz system clock; counts are derived from the times in nanoseconds.
 */
`ifndef DRAM_REFRESH_DEFINES_SVH
`define DRAM_REFRESH_DEFINES_SVH

`define CLK_PERIOD_NS      20
`define REFRESH_PERIOD_NS  2000000
`define ROWS_4K            64
`define ROWS_16K           128
`define ROW_BITS_4K        6
`define ROW_BITS_16K       7
`define CE_ON_MIN_NS       200
`define CE_OFF_MIN_NS      100
`define ADDR_SETUP_NS      20
`define CE_ON_CYCLES       ((`CE_ON_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CE_OFF_CYCLES      ((`CE_OFF_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYCLES       ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_INTERVAL_CYCLES (`REFRESH_PERIOD_NS / `CLK_PERIOD_NS / `ROWS_16K)

`endif

// *** core/dram_refresh_pkg.sv ***
/*
 * Types shared by the dynamic RAM refresh and cycle controller.
 * Assumes the constants header is compiled alongside.
 */
package dram_refresh_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_ACTIVE,
		ST_PRECHARGE
	} cycle_state_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_READ,
		OP_WRITE,
		OP_REFRESH
	} cycle_op_t;
endpackage

// *** core/dram_refresh_cycle_control.sv ***
/*
 * Refresh timer, refresh row counter, row address selector and cycle sequencer
 * for a board of multiplexed-address dynamic RAM chips.
 * Assumes a single 50 MHz clock and that the system request inputs are synchronous.
 */
`timescale 1ns/1ps
`include "dram_refresh_defines.svh"

// What this block does
// - One refresh cycle per row, all rows within every 2 ms interval.
// - Column address stays stable with full setup and hold during refresh.
// - Refresh row held in a dedicated 6- or 7-bit counter.
// - Selector puts the refresh counter on the row lines during refresh.
// - Periodic timer raises a request whenever a refresh is due.
// - Refresh and access cycles are arbitrated and never overlap.
// - Refresh may be disabled only when normal accesses visit every row.
// - Low, busy system address bits go to the RAM row address.
// - Every cycle runs to completion; chip enable never drops early.
// - Minimum chip enable on and off times are enforced.
module dram_refresh_cycle_control #(
	parameter int ROW_BITS          = `ROW_BITS_16K,
	parameter int COL_BITS          = `ROW_BITS_16K,
	parameter int REFRESH_INTERVAL  = `REFRESH_INTERVAL_CYCLES
) (
	// Clock and reset.
	input  wire logic                         i_clk,
	input  wire logic                         i_rst_n,
	// System request side.
	input  wire logic                         i_req,
	input  wire logic                         i_req_write,
	input  wire logic [ROW_BITS+COL_BITS-1:0] i_addr,
	input  wire logic                         i_refresh_enable,
	output logic                              o_busy,
	output logic                              o_done,
	output dram_refresh_pkg::cycle_op_t       o_op,
	// RAM array side.
	output logic [ROW_BITS-1:0]               o_ram_row,
	output logic [COL_BITS-1:0]               o_ram_col,
	output logic                              o_ram_ce,
	output logic                              o_ram_we
);
	import dram_refresh_pkg::*;

	localparam int ON_CYC  = `CE_ON_CYCLES;
	localparam int OFF_CYC = `CE_OFF_CYCLES;
	localparam int SU_CYC  = `SETUP_CYCLES;
	localparam int TW      = 32;
	localparam int SWEEP_CYC = `REFRESH_PERIOD_NS / `CLK_PERIOD_NS;

	// A due refresh may wait behind one access and must still finish before the next
	// tick, and the whole sweep of rows must fit the retention time.
	if (ROW_BITS != `ROW_BITS_4K && ROW_BITS != `ROW_BITS_16K) begin : g_bad_row_bits
		$error("ROW_BITS must be 6 or 7");
	end
	if (COL_BITS < 1) begin : g_bad_col_bits
		$error("COL_BITS must be at least 1");
	end
	if (REFRESH_INTERVAL < 2 * (ON_CYC + OFF_CYC + SU_CYC + 1)) begin : g_short_interval
		$error("REFRESH_INTERVAL too short to fit a refresh behind an access");
	end
	if (REFRESH_INTERVAL * (2 ** ROW_BITS) > SWEEP_CYC) begin : g_sweep
		$error("REFRESH_INTERVAL too long to sweep every row in time");
	end
	if (SU_CYC < 1 || SU_CYC > 256 || ON_CYC > 256 || OFF_CYC > 256) begin : g_bad_timing
		$error("Chip enable timing counts do not fit the cycle counter");
	end

	function automatic logic [TW-1:0] dec_timer(input logic [TW-1:0] v);
		dec_timer = (v == '0) ? '0 : v - 1'b1;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Refresh timer and row counter.

	logic [TW-1:0]       rtimer_reg, rtimer_next;
	logic                rpend_reg, rpend_next;
	logic [ROW_BITS-1:0] rrow_reg, rrow_next;
	logic                refresh_done;

	always_comb begin
		rtimer_next = dec_timer(rtimer_reg);
		rpend_next  = rpend_reg;
		rrow_next   = rrow_reg;
		if (rtimer_reg == '0) begin
			// Each tick covers one row so the full sweep fits the interval.
			rtimer_next = TW'(REFRESH_INTERVAL - 1);
			if (i_refresh_enable)
				rpend_next = 1'b1;
		end
		if (refresh_done) begin
			// A tick landing on the completion edge still stands pending.
			if (rtimer_reg != '0 || !i_refresh_enable)
				rpend_next = 1'b0;
			rrow_next = rrow_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rtimer_reg <= '0;
			rpend_reg  <= 1'b0;
			rrow_reg   <= '0;
		end else begin
			rtimer_reg <= rtimer_next;
			rpend_reg  <= rpend_next;
			rrow_reg   <= rrow_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Cycle sequencer.

	cycle_state_t          st_reg, st_next;
	cycle_op_t             op_reg, op_next;
	logic [7:0]            cnt_reg, cnt_next;
	logic [ROW_BITS-1:0]   row_reg, row_next;
	logic [COL_BITS-1:0]   col_reg, col_next;
	logic                  ce_reg, ce_next;
	logic                  we_reg, we_next;
	logic                  done_reg, done_next;
	logic                  busy_reg, busy_next;

	assign refresh_done = (st_reg == ST_PRECHARGE) && (cnt_reg == 8'h00)
	                      && (op_reg == OP_REFRESH);

	always_comb begin
		st_next   = st_reg;
		op_next   = op_reg;
		cnt_next  = (cnt_reg == 8'h00) ? 8'h00 : cnt_reg - 8'h01;
		row_next  = row_reg;
		col_next  = col_reg;
		ce_next   = ce_reg;
		we_next   = we_reg;
		done_next = 1'b0;
		case (st_reg)
			ST_IDLE: begin
				// Refresh wins over a waiting access; only one cycle runs at a time.
				if (rpend_reg) begin
					op_next  = OP_REFRESH;
					row_next = rrow_reg;
					// Column stays at its last value, so it is stable throughout.
					col_next = col_reg;
					we_next  = 1'b0;
					cnt_next = 8'(SU_CYC - 1);
					st_next  = ST_SETUP;
				end else if (i_req) begin
					op_next  = i_req_write ? OP_WRITE : OP_READ;
					// Low address bits feed the row so ordinary traffic refreshes too.
					row_next = i_addr[ROW_BITS-1:0];
					col_next = i_addr[ROW_BITS+COL_BITS-1:ROW_BITS];
					we_next  = i_req_write;
					cnt_next = 8'(SU_CYC - 1);
					st_next  = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_reg == 8'h00) begin
					ce_next  = 1'b1;
					cnt_next = 8'(ON_CYC - 1);
					st_next  = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				// No abort path exists: enable holds for its full minimum time.
				if (cnt_reg == 8'h00) begin
					ce_next  = 1'b0;
					we_next  = 1'b0;
					cnt_next = 8'(OFF_CYC - 1);
					st_next  = ST_PRECHARGE;
				end
			end
			ST_PRECHARGE: begin
				if (cnt_reg == 8'h00) begin
					done_next = 1'b1;
					op_next   = OP_NONE;
					st_next   = ST_IDLE;
				end
			end
			default: begin
				st_next = ST_IDLE;
				ce_next = 1'b0;
				we_next = 1'b0;
				op_next = OP_NONE;
			end
		endcase
		// Busy follows the next state so it rises on the very edge that takes a cycle.
		busy_next = (st_next != ST_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg   <= ST_IDLE;
			op_reg   <= OP_NONE;
			cnt_reg  <= 8'h00;
			row_reg  <= '0;
			col_reg  <= '0;
			ce_reg   <= 1'b0;
			we_reg   <= 1'b0;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			op_reg   <= op_next;
			cnt_reg  <= cnt_next;
			row_reg  <= row_next;
			col_reg  <= col_next;
			ce_reg   <= ce_next;
			we_reg   <= we_next;
			done_reg <= done_next;
			busy_reg <= busy_next;
		end
	end

	assign o_busy    = busy_reg;
	assign o_done    = done_reg;
	assign o_op      = op_reg;
	assign o_ram_row = row_reg;
	assign o_ram_col = col_reg;
	assign o_ram_ce  = ce_reg;
	assign o_ram_we  = we_reg;
endmodule

// *** testbench/dram_refresh_sva.sv ***
/* Assertions on the controller ports.
   Bound to the controller by the bench. */
`timescale 1ns/1ps
module dram_refresh_sva
	import dram_refresh_pkg::*;
#(parameter int ROW_BITS = 7, COL_BITS = 7, REFRESH_INTERVAL = 40) (
	input wire logic i_clk, i_rst_n, i_refresh_enable, o_busy, o_done, o_ram_ce,
	input wire logic [1:0] o_op,
	input wire logic [ROW_BITS-1:0] o_ram_row,
	input wire logic [COL_BITS-1:0] o_ram_col
);
	logic busy_q;
	logic [ROW_BITS-1:0] ref_row;
	int gap;
	wire ref_take = o_busy && !busy_q && o_op == OP_REFRESH;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// The gap bound allows one access cycle of delay behind a due refresh.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_q <= 1'b0;
			ref_row <= '0;
			gap <= 0;
		end else begin
			busy_q <= o_busy;
			ref_row <= ref_row + ref_take;
			gap <= (ref_take || !i_refresh_enable) ? 0 : gap + 1;
		end
	end
	AST_CE_SETUP: assert property ($rose(o_busy) |=> $rose(o_ram_ce))
		else $error("enable not one cycle after take");
	AST_CE_ON: assert property ($rose(o_ram_ce) |-> o_ram_ce[*5] ##1 o_ram_ce[*5] ##1 !o_ram_ce)
		else $error("enable on time wrong");
	AST_CE_OFF: assert property ($fell(o_ram_ce) |-> !o_ram_ce[*5])
		else $error("enable off time short");
	AST_HOLD: assert property (o_ram_ce |-> $stable(o_ram_row) && $stable(o_ram_col))
		else $error("address moved under enable");
	AST_BUSY: assert property (o_ram_ce |-> o_busy)
		else $error("enable outside a cycle");
	AST_DONE: assert property ($rose(o_ram_ce) |-> ##15 o_done && !o_ram_ce)
		else $error("done out of place");
	AST_REF_ROW: assert property (ref_take |-> o_ram_row == ref_row)
		else $error("refresh row wrong");
	AST_GAP: assert property (gap <= REFRESH_INTERVAL + 40)
		else $error("refresh overdue");
	cover property (ref_take);
	cover property ($rose(o_busy) && o_op == OP_WRITE);
	cover property ($rose(o_busy) && o_op == OP_READ);
endmodule

// *** testbench/dram_array_model.sv ***
/* Row-level model of the RAM array.
   Shares the controller clock. */
`timescale 1ns/1ps
module dram_array_model #(parameter int ROW_BITS = 7) (
	input wire logic i_clk, i_ce, i_clear,
	input wire logic [ROW_BITS-1:0] i_row,
	output logic [(1<<ROW_BITS)-1:0] o_rows_hit
);
	logic ce_q;
	// A cycle restores its whole row, so rows alone are tracked.
	always_ff @(posedge i_clk) begin
		ce_q <= i_ce;
		if (i_clear)
			o_rows_hit <= '0;
		else if (i_ce && !ce_q)
			o_rows_hit[i_row] <= 1'b1;
	end
endmodule

// *** testbench/dram_refresh_cycle_control_test.sv ***
/* Self-checking bench for the controller.
   Needs the checker and the array model. */
`timescale 1ns/1ps
`include "dram_refresh_defines.svh"
module dram_refresh_cycle_control_test;
	import dram_refresh_pkg::*;
	logic i_clk = 0, i_rst_n = 0, i_req = 0, i_req_write = 0, i_refresh_enable = 1;
	logic o_busy, o_done, o_ram_ce, o_ram_we, clr = 1, busy_q = 0;
	logic [13:0] i_addr = '0;
	cycle_op_t o_op;
	logic [6:0] o_ram_row, o_ram_col, ref_row = '0;
	logic [127:0] hit;
	logic [31:0] seed = 32'h00015de6;
	int errors = 0, tests_run = 0, refs = 0, cyc = 0;
	dram_refresh_cycle_control #(.REFRESH_INTERVAL(40)) dut_u (.i_clk, .i_rst_n, .i_req,
		.i_req_write, .i_addr, .i_refresh_enable, .o_busy, .o_done, .o_op, .o_ram_row,
		.o_ram_col, .o_ram_ce, .o_ram_we);
	dram_array_model model_u (.i_clk, .i_ce(o_ram_ce), .i_clear(clr), .i_row(o_ram_row),
		.o_rows_hit(hit));
	always #10 i_clk = ~i_clk;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic acc(input logic w, input logic [13:0] a);
		int n;
		i_req <= 1'b1;
		i_req_write <= w;
		i_addr <= a;
		do @(posedge i_clk); while (!(o_busy && o_op !== OP_REFRESH));
		i_req <= 1'b0;
		chk(o_op, w ? OP_WRITE : OP_READ);
		chk(o_ram_row, a[6:0]);
		chk(o_ram_col, a[13:7]);
		chk(o_ram_we, w);
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_done !== 1'b1);
		chk(16'(n), 16'(`SETUP_CYCLES + `CE_ON_CYCLES + `CE_OFF_CYCLES));
	endtask
	always @(posedge i_clk) begin
		busy_q <= o_busy;
		cyc <= cyc + 1;
		if (o_busy && !busy_q && o_op === OP_REFRESH) begin
			chk(o_ram_row, ref_row);
			ref_row <= ref_row + 1'b1;
			refs <= refs + 1;
		end
		if (cyc == 20000) begin
			errors++;
			end_sim();
		end
	end
	initial begin
		int n;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		clr <= 1'b0;
		@(posedge i_clk);
		acc(1'b0, '0);
		acc(1'b1, '1);
		for (int i = 0; i < 40; i++) begin
			seed = nx(seed);
			acc(seed[20], seed[13:0]);
		end
		$display("test access done");
		while (refs < 130) @(posedge i_clk);
		chk(&hit, 1'b1);
		$display("test sweep done");
		i_refresh_enable <= 1'b0;
		repeat (20) @(posedge i_clk);
		n = refs;
		repeat (200) @(posedge i_clk);
		chk(16'(refs), 16'(n));
		$display("test refresh off done");
		end_sim();
	end
endmodule
bind dram_refresh_cycle_control dram_refresh_sva #(.ROW_BITS(ROW_BITS), .COL_BITS(COL_BITS),
	.REFRESH_INTERVAL(REFRESH_INTERVAL)) sva_u (.i_clk, .i_rst_n, .i_refresh_enable, .o_busy,
	.o_done, .o_ram_ce, .o_op, .o_ram_row, .o_ram_col);
